// file: inc/blin_map.svh
// constants of the break-point lineariser
`ifndef BLIN_MAP_SVH
`define BLIN_MAP_SVH
`define BLIN_MAX_PTS    17
`define BLIN_MIN_PTS    5'h02
`define BLIN_CUR_LO     16'h0ed8
`define BLIN_CUR_HI     16'h5208
`define BLIN_DEF_CUR0   16'h0fa0
`define BLIN_DEF_CUR1   16'h4e20
`define BLIN_DEF_TOP4   20'h003e8
`define BLIN_DEF_TOP5   20'h02710
`define BLIN_CUR_DIGITS 3'h5
`define BLIN_KEY_SEL    0
`define BLIN_KEY_UP     1
`define BLIN_KEY_DOWN   2
`define BLIN_KEY_EXIT   3
`endif

// file: inc/blin_pkg.sv
// types shared by the lineariser modules
package blin_pkg;
   typedef logic        [15:0] blin_cur_type;
   typedef logic signed [19:0] blin_point_value_menu_type;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADD_PROMPT, ST_DEL_PROMPT, ST_IN_PROMPT, ST_POINT_VALUE_MENU_PROMPT,
      ST_ADD_EDIT, ST_DEL_EDIT, ST_IN_SEL, ST_POINT_VALUE_MENU_SEL, ST_IN_DIGIT, ST_POINT_VALUE_MENU_DIGIT
   } blin_state_type;
   function automatic int blin_pow10(input int d);
      int p;
      p = 1;
      for (int i = 0; i < d; i++) begin
         p = p * 10;
      end
      return p;
   endfunction : blin_pow10
endpackage : blin_pkg

// file: inc/blin_tab_if.sv
// table and request carrier between the menu logic and the interpolator
`timescale 1ns/1ps
interface blin_tab_if #(parameter int N_PTS = 17);
   import blin_pkg::*;
   logic                         [4:0] count;
   blin_cur_type  [N_PTS-1:0]          cur;
   blin_point_value_menu_type [N_PTS-1:0]          point_value_menu;
   logic                               start;
   blin_cur_type                       x;
   logic                               busy;
   logic                               done;
   blin_point_value_menu_type                      y;
   modport owner (output count, cur, point_value_menu, start, x, input busy, done, y);
   modport calc  (input count, cur, point_value_menu, start, x, output busy, done, y);
endinterface : blin_tab_if

// file: rtl/blin_interp.sv
// segment search and straight-line interpolation with a serial divider
`timescale 1ns/1ps
`include "blin_map.svh"
module blin_interp import blin_pkg::*; #(
   parameter int N_PTS = `BLIN_MAX_PTS
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   blin_tab_if.calc ifc
);
   typedef struct packed {
      logic               busy;
      logic               done;
      logic               neg;
      logic         [5:0] cnt;
      logic        [37:0] quo;
      logic        [17:0] rem;
      logic        [16:0] den;
      blin_point_value_menu_type      base;
      blin_point_value_menu_type      y;
   } blin_interp_state_type;

   blin_interp_state_type r;
   blin_interp_state_type next_r;

   // --------------------------------------------------------------
   // segment choice: below point 0 and above the last point the
   // end segments carry on with their own slope
   // --------------------------------------------------------------
   function automatic logic [4:0] seg_lo(input blin_cur_type x);
      logic [4:0] k;
      k = 5'h00;
      for (int i = 1; i < N_PTS - 1; i++) begin
         if (5'(i) < ifc.count - 5'h01 && x >= ifc.cur[i]) begin
            k = 5'(i);
         end
      end
      return k;
   endfunction : seg_lo

   always_comb begin
      logic        [4:0] k;
      logic signed [16:0] dx;
      logic signed [20:0] dy;
      logic signed [37:0] prod;
      logic        [18:0] trial;
      k      = 5'h00;
      dx     = '0;
      dy     = '0;
      prod   = '0;
      trial  = '0;
      next_r = r;
      next_r.done = 1'b0;
      if (!r.busy && ifc.start) begin
         // y = y0 + (x - x0) * (y1 - y0) / (x1 - x0)
         k    = seg_lo(ifc.x);
         dx   = $signed({1'b0, ifc.x}) - $signed({1'b0, ifc.cur[k]});
         dy   = 21'(ifc.point_value_menu[k + 5'h01]) - 21'(ifc.point_value_menu[k]);
         prod = 38'(dx) * 38'(dy);
         next_r.neg  = prod[37];
         next_r.quo  = prod[37] ? 38'(-prod) : prod;
         next_r.den  = 17'(ifc.cur[k + 5'h01]) - 17'(ifc.cur[k]);
         if (next_r.den == 17'h00000) begin
            next_r.den = 17'h00001;
         end
         next_r.base = ifc.point_value_menu[k];
         next_r.rem  = '0;
         next_r.cnt  = 6'h26;
         next_r.busy = 1'b1;
      end else if (r.busy) begin
         // restoring division, one quotient bit per clock
         trial = {r.rem, r.quo[37]};
         next_r.quo = {r.quo[36:0], 1'b0};
         if (trial >= 19'(r.den)) begin
            trial = trial - 19'(r.den);
            next_r.quo[0] = 1'b1;
         end
         next_r.rem = trial[17:0];
         next_r.cnt = r.cnt - 6'h01;
         if (r.cnt == 6'h01) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.y    = r.base + (r.neg ? -20'(next_r.quo) : 20'(next_r.quo));
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ifc.busy = r.busy;
   assign ifc.done = r.done;
   assign ifc.y    = r.y;
endmodule : blin_interp

// file: rtl/blin_top.sv
// break-point lineariser: operator menu, point table and display output
`timescale 1ns/1ps
`include "blin_map.svh"
module blin_top import blin_pkg::*; #(
   parameter int N_PTS  = `BLIN_MAX_PTS,
   parameter int DIGITS = 4
) (
   input  wire logic           i_clk,
   input  wire logic           i_nrst,
   input  wire logic           i_key_select_n,
   input  wire logic           i_key_up_n,
   input  wire logic           i_key_down_n,
   input  wire logic           i_key_exit_n,
   input  wire logic           i_enter_cal,
   input  wire logic           i_restore_defaults,
   input  wire logic           i_lin_enable,
   input  wire logic           i_sample_valid,
   input  wire blin_cur_type   i_current,
   input  wire blin_point_value_menu_type  i_linear_value,
   output blin_state_type      o_menu,
   output logic          [4:0] o_sel,
   output logic          [4:0] o_count,
   output logic          [2:0] o_digit,
   output logic signed  [20:0] o_edit,
   output logic                o_fail,
   output logic                o_cal_done,
   output blin_point_value_menu_type       o_display,
   output logic                o_under,
   output logic                o_over
);
   // refuse sizes the table and digit logic cannot serve
   if (N_PTS < 2 || N_PTS > `BLIN_MAX_PTS) begin : g_bad_pts
      $error("point table size must be 2 to 17");
   end
   if (DIGITS != 4 && DIGITS != 5) begin : g_bad_digits
      $error("display must have 4 or 5 digits");
   end

   typedef struct packed {
      logic                     [3:0] key_s1;
      logic                     [3:0] key_s2;
      logic                     [3:0] key_prev;
      blin_state_type                 st;
      logic                           last_del;
      logic                     [4:0] count;
      logic                     [4:0] sel;
      logic                     [2:0] digit;
      logic signed             [20:0] edit;
      logic                           fail;
      logic                           cal_done;
      logic                           start;
      blin_point_value_menu_type                  display;
      logic                           under;
      logic                           over;
      blin_cur_type  [N_PTS-1:0]      cur;
      blin_point_value_menu_type [N_PTS-1:0]      point_value_menu;
   } blin_top_state_type;

   localparam blin_point_value_menu_type DEF_TOP  = (DIGITS == 4) ? `BLIN_DEF_TOP4 : `BLIN_DEF_TOP5;
   localparam logic    [2:0] POINT_VALUE_MENU_DIG = 3'(DIGITS);
   localparam int            OVER_LIM = blin_pow10(DIGITS) - 1;
   localparam int            UNDR_LIM = 1 - blin_pow10(DIGITS - 1);

   // --------------------------------------------------------------
   // reset and restore image
   // --------------------------------------------------------------
   function automatic blin_top_state_type defaults();
      blin_top_state_type s;
      s          = '0;
      s.key_s1   = 4'hf;
      s.key_s2   = 4'hf;
      s.key_prev = 4'hf;
      s.st       = ST_IDLE;
      s.count    = `BLIN_MIN_PTS;
      s.cur[0]   = `BLIN_DEF_CUR0;
      s.cur[1]   = `BLIN_DEF_CUR1;
      s.point_value_menu[1]  = DEF_TOP;
      return s;
   endfunction : defaults

   localparam blin_top_state_type RST = defaults();

   blin_top_state_type r;
   blin_top_state_type next_r;

   blin_tab_if #(.N_PTS(N_PTS)) tab ();

   blin_interp #(.N_PTS(N_PTS)) u_interp (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .ifc    (tab.calc)
   );

   // --------------------------------------------------------------
   // current check against the range and both neighbours
   // --------------------------------------------------------------
   function automatic logic cur_ok(input blin_top_state_type s);
      logic ok;
      ok = s.edit > 21'(`BLIN_CUR_LO) - 21'sh1 && s.edit < 21'(`BLIN_CUR_HI) + 21'sh1;
      if (s.sel != 5'h00 && s.edit <= 21'(s.cur[s.sel - 5'h01])) begin
         ok = 1'b0;
      end
      if (s.sel + 5'h01 < s.count && s.edit >= 21'(s.cur[s.sel + 5'h01])) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : cur_ok

   always_comb begin
      logic [3:0] press;
      logic [2:0] ndig;
      logic signed [20:0] step;
      press  = r.key_prev & ~r.key_s2;
      ndig   = (r.st == ST_IN_DIGIT) ? `BLIN_CUR_DIGITS : POINT_VALUE_MENU_DIG;
      step   = 21'(blin_pow10(int'(r.digit)));
      next_r        = r;
      next_r.key_s1 = {i_key_exit_n, i_key_down_n, i_key_up_n, i_key_select_n};
      next_r.key_s2 = r.key_s1;
      next_r.key_prev = r.key_s2;
      next_r.cal_done = 1'b0;
      next_r.start    = 1'b0;
      if (press != 4'h0) begin
         next_r.fail = 1'b0;
      end

      // ------------------------------------------------------------
      // menu walk
      // ------------------------------------------------------------
      unique case (r.st)
         ST_IDLE: begin
            if (i_enter_cal) begin
               next_r.st = ST_ADD_PROMPT;
            end
         end
         ST_ADD_PROMPT, ST_DEL_PROMPT, ST_IN_PROMPT, ST_POINT_VALUE_MENU_PROMPT: begin
            next_r.sel = 5'h00;
            if (press[`BLIN_KEY_UP]) begin
               next_r.st = (r.st == ST_POINT_VALUE_MENU_PROMPT) ? ST_ADD_PROMPT
                         : blin_state_type'(r.st + 4'h1);
            end else if (press[`BLIN_KEY_DOWN]) begin
               next_r.st = (r.st == ST_ADD_PROMPT) ? ST_POINT_VALUE_MENU_PROMPT
                         : blin_state_type'(r.st - 4'h1);
            end else if (press[`BLIN_KEY_SEL]) begin
               next_r.st = (r.st == ST_ADD_PROMPT) ? ST_ADD_EDIT
                         : (r.st == ST_DEL_PROMPT) ? ST_DEL_EDIT
                         : (r.st == ST_IN_PROMPT)  ? ST_IN_SEL : ST_POINT_VALUE_MENU_SEL;
            end else if (press[`BLIN_KEY_EXIT]) begin
               next_r.st       = ST_IDLE;
               next_r.cal_done = 1'b1;
            end
         end
         ST_ADD_EDIT, ST_DEL_EDIT, ST_IN_SEL, ST_POINT_VALUE_MENU_SEL: begin
            if (press[`BLIN_KEY_UP] && r.sel + 5'h01 < r.count) begin
               next_r.sel = r.sel + 5'h01;
            end else if (press[`BLIN_KEY_DOWN] && r.sel != 5'h00) begin
               next_r.sel = r.sel - 5'h01;
            end else if (press[`BLIN_KEY_EXIT]) begin
               next_r.st = (r.st == ST_IN_SEL)   ? ST_IN_PROMPT
                         : (r.st == ST_POINT_VALUE_MENU_SEL) ? ST_POINT_VALUE_MENU_PROMPT
                         : (r.last_del ? ST_DEL_PROMPT : ST_ADD_PROMPT);
            end else if (press[`BLIN_KEY_SEL]) begin
               next_r.digit = 3'h0;
               if (r.st == ST_ADD_EDIT) begin
                  next_r.last_del = 1'b0;
                  if (r.count < 5'(N_PTS)) begin
                     for (int i = 1; i < N_PTS; i++) begin
                        if (5'(i) > r.sel) begin
                           next_r.cur[i]  = r.cur[i-1];
                           next_r.point_value_menu[i] = r.point_value_menu[i-1];
                        end
                     end
                     next_r.count = r.count + 5'h01;
                  end
               end else if (r.st == ST_DEL_EDIT) begin
                  next_r.last_del = 1'b1;
                  if (r.count > `BLIN_MIN_PTS) begin
                     for (int i = 0; i < N_PTS - 1; i++) begin
                        if (5'(i) >= r.sel) begin
                           next_r.cur[i]  = r.cur[i+1];
                           next_r.point_value_menu[i] = r.point_value_menu[i+1];
                        end
                     end
                     next_r.count = r.count - 5'h01;
                     if (r.sel + 5'h01 >= r.count) begin
                        next_r.sel = r.count - 5'h02;
                     end
                  end
               end else if (r.st == ST_IN_SEL) begin
                  next_r.edit = 21'(r.cur[r.sel]);
                  next_r.st   = ST_IN_DIGIT;
               end else begin
                  next_r.edit = 21'(r.point_value_menu[r.sel]);
                  next_r.st   = ST_POINT_VALUE_MENU_DIGIT;
               end
            end
         end
         ST_IN_DIGIT, ST_POINT_VALUE_MENU_DIGIT: begin
            // digit under edit steps by its own power of ten
            if (press[`BLIN_KEY_UP]) begin
               next_r.edit = r.edit + step;
            end else if (press[`BLIN_KEY_DOWN]) begin
               next_r.edit = r.edit - step;
            end else if (press[`BLIN_KEY_SEL]) begin
               next_r.digit = (r.digit + 3'h1 >= ndig) ? 3'h0 : r.digit + 3'h1;
            end else if (press[`BLIN_KEY_EXIT]) begin
               if (r.st == ST_POINT_VALUE_MENU_DIGIT) begin
                  next_r.point_value_menu[r.sel] = 20'(r.edit);
                  next_r.st          = ST_POINT_VALUE_MENU_SEL;
               end else begin
                  // a rejected current leaves the stored point untouched
                  if (cur_ok(r)) begin
                     next_r.cur[r.sel] = 16'(r.edit);
                  end else begin
                     next_r.fail = 1'b1;
                  end
                  next_r.st = ST_IN_SEL;
               end
            end
         end
      endcase

      if (i_restore_defaults) begin
         next_r.count = RST.count;
         next_r.cur   = RST.cur;
         next_r.point_value_menu  = RST.point_value_menu;
         next_r.sel   = 5'h00;
      end

      // ------------------------------------------------------------
      // measurement path; table survives any change of i_lin_enable
      // ------------------------------------------------------------
      if (i_sample_valid && !tab.busy && !r.start) begin
         if (i_lin_enable) begin
            next_r.start = 1'b1;
         end else begin
            next_r.display = i_linear_value;
         end
      end
      if (tab.done) begin
         next_r.display = tab.y;
      end
      // same limits whether or not the lineariser is on
      next_r.over  = int'(next_r.display) > OVER_LIM;
      next_r.under = int'(next_r.display) < UNDR_LIM;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= RST;
      end else begin
         r <= next_r;
      end
   end

   assign tab.count = r.count;
   assign tab.cur   = r.cur;
   assign tab.point_value_menu  = r.point_value_menu;
   assign tab.start = r.start;
   assign tab.x     = i_current;

   assign o_menu     = r.st;
   assign o_sel      = r.sel;
   assign o_count    = r.count;
   assign o_digit    = r.digit;
   assign o_edit     = r.edit;
   assign o_fail     = r.fail;
   assign o_cal_done = r.cal_done;
   assign o_display  = r.display;
   assign o_under    = r.under;
   assign o_over     = r.over;
endmodule : blin_top

// file: bench/blin_operator.sv
// operator model: front-panel push-buttons with pull-ups
`timescale 1ns/1ps
`include "blin_map.svh"
module blin_operator (
   input  wire logic i_clk,
   output logic      o_select_n,
   output logic      o_up_n,
   output logic      o_down_n,
   output logic      o_exit_n
);
   // ----
   // pins idle high
   // ----
   logic [3:0] pins_n = 4'hf;
   assign o_select_n = pins_n[`BLIN_KEY_SEL];
   assign o_up_n     = pins_n[`BLIN_KEY_UP];
   assign o_down_n   = pins_n[`BLIN_KEY_DOWN];
   assign o_exit_n   = pins_n[`BLIN_KEY_EXIT];
   // two clocks low, then released long enough for the menu to act
   task automatic press(input int k);
      @(negedge i_clk);
      pins_n[k] = 1'b0;
      repeat (2) @(negedge i_clk);
      pins_n[k] = 1'b1;
      repeat (5) @(negedge i_clk);
   endtask : press
endmodule : blin_operator

// file: bench/blin_top_props.sv
// port assertions of the break-point lineariser
`timescale 1ns/1ps
module blin_top_props import blin_pkg::*; #(
   parameter int N_PTS  = 17,
   parameter int DIGITS = 4
) (
   input wire logic           i_clk,
   input wire logic           i_nrst,
   input wire logic           i_restore_defaults,
   input wire logic           i_lin_enable,
   input wire logic           i_sample_valid,
   input wire blin_point_value_menu_type  i_linear_value,
   input wire blin_state_type o_menu,
   input wire logic     [4:0] o_sel,
   input wire logic     [4:0] o_count,
   input wire logic           o_fail,
   input wire logic           o_cal_done,
   input wire blin_point_value_menu_type  o_display,
   input wire logic           o_under,
   input wire logic           o_over
);
   // ----
   // limits and sequences
   // ----
   localparam int LOW_LIM  = 1 - 10 ** (DIGITS - 1);
   localparam int HIGH_LIM = 10 ** DIGITS - 1;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_exit_prompt;
      o_menu inside {ST_ADD_PROMPT, ST_DEL_PROMPT, ST_IN_PROMPT, ST_POINT_VALUE_MENU_PROMPT} ##1 o_cal_done;
   endsequence
   // a bypass sample only lands once the interpolator can no longer be
   // busy, so count how long the lineariser has been off
   localparam logic [5:0] OFF_SETTLE = 6'h2d;
   logic [5:0] off_cnt;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         off_cnt <= 6'h00;
      end else if (i_lin_enable) begin
         off_cnt <= 6'h00;
      end else if (off_cnt != OFF_SETTLE) begin
         off_cnt <= off_cnt + 6'h01;
      end
   end
   sequence s_bypass_take;
      off_cnt == OFF_SETTLE && i_sample_valid;
   endsequence
   // ----
   // assertions
   // ----
   count_range_a: assert property (
      o_count >= 5'h02 && o_count <= N_PTS) else $error("point count out of range");
   count_add_a: assert property (
      o_count == $past(o_count) + 5'h01 |-> $past(o_menu) == ST_ADD_EDIT)
      else $error("count rose outside add edit");
   count_del_a: assert property (
      o_count < $past(o_count) |-> $past(i_restore_defaults) ||
      ($past(o_menu) == ST_DEL_EDIT && o_count == $past(o_count) - 5'h01))
      else $error("count fell wrongly");
   restore_count_a: assert property (
      i_restore_defaults |=> o_count == 5'h02) else $error("restore left wrong count");
   sel_bound_a: assert property (
      o_menu inside {ST_IN_SEL, ST_POINT_VALUE_MENU_SEL} |-> o_sel < o_count)
      else $error("selected point beyond table");
   fail_source_a: assert property (
      $rose(o_fail) |-> $past(o_menu) == ST_IN_DIGIT && o_menu == ST_IN_SEL)
      else $error("error flag without current entry");
   cal_done_src_a: assert property (
      o_cal_done |-> o_menu == ST_IDLE && !$past(o_cal_done)) else $error("stray done pulse");
   cal_done_len_a: assert property (
      s_exit_prompt |=> !o_cal_done) else $error("done pulse too long");
   under_flag_a: assert property (
      o_under == (o_display < LOW_LIM)) else $error("under flag mismatch");
   over_flag_a: assert property (
      o_over == (o_display > HIGH_LIM)) else $error("over flag mismatch");
   pass_through_a: assert property (
      s_bypass_take |=> o_display == $past(i_linear_value)) else $error("bypass value wrong");
endmodule : blin_top_props

bind blin_top blin_top_props #(.N_PTS(N_PTS), .DIGITS(DIGITS)) u_props (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_restore_defaults(i_restore_defaults),
   .i_lin_enable(i_lin_enable), .i_sample_valid(i_sample_valid),
   .i_linear_value(i_linear_value), .o_menu(o_menu),
   .o_sel(o_sel), .o_count(o_count), .o_fail(o_fail), .o_cal_done(o_cal_done),
   .o_display(o_display), .o_under(o_under), .o_over(o_over));

// file: bench/blin_top_tb_top.sv
// self-checking bench of the break-point lineariser
`timescale 1ns/1ps
`include "blin_map.svh"
module blin_top_tb_top import blin_pkg::*; ;
   // ----
   // stimulus and design
   // ----
   logic           i_clk = 1'b0;
   logic           i_nrst = 1'b0;
   logic           k_sel_n, k_up_n, k_dn_n, k_ex_n;
   logic           enter_cal = 1'b0;
   logic           restore = 1'b0;
   logic           lin_en = 1'b1;
   logic           sample_valid = 1'b0;
   blin_cur_type   cur_in = 16'h0fa0;
   blin_point_value_menu_type  lin_val = 20'h00000;
   blin_state_type o_menu;
   logic     [4:0] o_sel, o_count;
   logic     [2:0] o_digit;
   logic signed [20:0] o_edit;
   logic           o_fail, o_cal_done, o_under, o_over;
   blin_point_value_menu_type  o_display;
   int             err_total = 0;
   int             checks_done = 0;
   int             cal_seen = 0;
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_cal_done === 1'b1) cal_seen <= cal_seen + 1;
   blin_operator uop (.i_clk(i_clk), .o_select_n(k_sel_n), .o_up_n(k_up_n),
      .o_down_n(k_dn_n), .o_exit_n(k_ex_n));
   blin_top #(.N_PTS(17), .DIGITS(4)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_key_select_n(k_sel_n), .i_key_up_n(k_up_n), .i_key_down_n(k_dn_n),
      .i_key_exit_n(k_ex_n), .i_enter_cal(enter_cal), .i_restore_defaults(restore),
      .i_lin_enable(lin_en), .i_sample_valid(sample_valid), .i_current(cur_in),
      .i_linear_value(lin_val), .o_menu(o_menu), .o_sel(o_sel), .o_count(o_count),
      .o_digit(o_digit), .o_edit(o_edit), .o_fail(o_fail), .o_cal_done(o_cal_done),
      .o_display(o_display), .o_under(o_under), .o_over(o_over));
   // ----
   // helpers
   // ----
   task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %0d expected %0d", $time, seen, exp);
      end
   endtask : check
   function automatic int lin_y(input int x, input int c0, input int c1, input int d0,
                                input int d1);
      return d0 + (x - c0) * (d1 - d0) / (c1 - c0);
   endfunction : lin_y
   // interpolator needs about 41 clocks; input held meanwhile
   task automatic measure(input int x);
      @(negedge i_clk);
      cur_in = 16'(x);
      sample_valid = 1'b1;
      @(negedge i_clk);
      sample_valid = 1'b0;
      repeat (50) @(negedge i_clk);
   endtask : measure
   task automatic keys(input int k, input int n);
      for (int i = 0; i < n; i++) begin
         uop.press(k);
      end
   endtask : keys
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      check(o_count, 2);
      measure(12000);
      check(o_display, lin_y(12000, 4000, 20000, 0, 1000));
      measure(2000);
      check(o_display, lin_y(2000, 4000, 20000, 0, 1000));
      measure(21000);
      check(o_display, lin_y(21000, 4000, 20000, 0, 1000));
   endtask : t_reset
   task automatic t_add;
      @(negedge i_clk);
      enter_cal = 1'b1;
      @(negedge i_clk);
      enter_cal = 1'b0;
      check(o_menu, ST_ADD_PROMPT);
      keys(`BLIN_KEY_SEL, 1);
      keys(`BLIN_KEY_UP, 1);
      check(o_sel, 1);
      keys(`BLIN_KEY_SEL, 1);
      check(o_count, 3);
      measure(12000);
      check(o_display, lin_y(12000, 4000, 20000, 0, 1000));
      keys(`BLIN_KEY_SEL, 15);
      check(o_count, 17);
      keys(`BLIN_KEY_EXIT, 1);
      check(o_menu, ST_ADD_PROMPT);
   endtask : t_add
   task automatic t_del;
      logic [4:0] s;
      keys(`BLIN_KEY_UP, 1);
      keys(`BLIN_KEY_SEL, 1);
      s = o_sel;
      keys(`BLIN_KEY_UP, 1);
      check(o_sel, (s < 5'h10) ? s + 5'h01 : 5'h10);
      keys(`BLIN_KEY_SEL, 16);
      check(o_count, 2);
      measure(12000);
      check(o_display, lin_y(12000, 4000, 20000, 0, 1000));
      keys(`BLIN_KEY_EXIT, 1);
      check(o_menu, ST_DEL_PROMPT);
   endtask : t_del
   task automatic t_cur;
      keys(`BLIN_KEY_UP, 1);
      keys(`BLIN_KEY_SEL, 1);
      check(o_sel, 0);
      keys(`BLIN_KEY_UP, 1);
      keys(`BLIN_KEY_SEL, 1);
      check(o_edit, 20000);
      keys(`BLIN_KEY_SEL, 4);
      check(o_digit, 4);
      keys(`BLIN_KEY_DOWN, 1);
      keys(`BLIN_KEY_EXIT, 1);
      check(o_fail, 0);
      keys(`BLIN_KEY_DOWN, 1);
      keys(`BLIN_KEY_SEL, 5);
      keys(`BLIN_KEY_UP, 1);
      keys(`BLIN_KEY_EXIT, 1);
      check(o_fail, 1);
      keys(`BLIN_KEY_SEL, 1);
      check(o_edit, 4000);
      keys(`BLIN_KEY_SEL, 2);
      keys(`BLIN_KEY_DOWN, 3);
      keys(`BLIN_KEY_EXIT, 1);
      check(o_fail, 1);
      measure(7000);
      check(o_display, lin_y(7000, 4000, 10000, 0, 1000));
   endtask : t_cur
   task automatic t_point_value_menu;
      keys(`BLIN_KEY_EXIT, 1);
      keys(`BLIN_KEY_UP, 1);
      keys(`BLIN_KEY_SEL, 3);
      keys(`BLIN_KEY_UP, 2);
      keys(`BLIN_KEY_EXIT, 1);
      check(o_menu, ST_POINT_VALUE_MENU_SEL);
      measure(7000);
      check(o_display, lin_y(7000, 4000, 10000, 20, 1000));
      keys(`BLIN_KEY_EXIT, 2);
      check(o_menu, ST_IDLE);
      check(cal_seen, 1);
   endtask : t_point_value_menu
   task automatic t_lin;
      @(negedge i_clk);
      lin_en = 1'b0;
      sample_valid = 1'b1;
      lin_val = -20'sd1000;
      repeat (50) @(negedge i_clk);
      check(o_display, -1000);
      check(o_under, 1);
      lin_val = 20'sd10000;
      repeat (3) @(negedge i_clk);
      check(o_over, 1);
      check(o_under, 0);
      sample_valid = 1'b0;
      lin_en = 1'b1;
      measure(7000);
      check(o_display, lin_y(7000, 4000, 10000, 20, 1000));
      restore = 1'b1;
      @(negedge i_clk);
      restore = 1'b0;
      measure(12000);
      check(o_display, lin_y(12000, 4000, 20000, 0, 1000));
   endtask : t_lin
   // ----
   // run control
   // ----
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (8) @(negedge i_clk);
      i_nrst = 1'b1;
      t_reset;
      t_add;
      t_del;
      t_cur;
      t_point_value_menu;
      t_lin;
      end_of_test;
   end
   // hang guard well above the expected run length
   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      end_of_test;
   end
endmodule : blin_top_tb_top
